// ---- include/sfp_params.svh ----
/*
 * timing counts, widths and reset values of the synchronous parallel fifo port.
 * assumes it is included by bare name wherever these constants are used.
 */
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH

// =============================================================
// widths and depths
`define SFP_DATA_W        8
`define SFP_FIFO_DEPTH    16

// =============================================================
// timing
`define SFP_CLK_PERIOD_NS 100
`define SFP_IFCLK_MHZ     60
`define SFP_IFCLK_DIV     2

// =============================================================
// reset values of the port pins
`define SFP_FLAG_RST      1'b1
`define SFP_DATA_RST      8'h00

`endif

// ---- include/sfp_pkg.sv ----
/*
 * types shared by the synchronous parallel fifo port.
 * assumes nothing of its surroundings.
 */
package sfp_pkg;

	// =============================================================
	// port operating mode, one-hot
	typedef enum logic [1:0] {
		SFP_MODE_IDLE = 2'b01,
		SFP_MODE_SYNC = 2'b10
	} sfp_mode_type;

endpackage : sfp_pkg

// ---- hdl/sfp_byte_fifo.sv ----
/*
 * byte fifo used for the receive and transmit buffers of the port.
 * assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "sfp_params.svh"

module sfp_byte_fifo #(
	parameter int W     = `SFP_DATA_W,
	parameter int DEPTH = `SFP_FIFO_DEPTH
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       push,
	input  wire logic [W-1:0]               push_data,
	input  wire logic                       pop,
	output logic      [W-1:0]               rd_data,
	output logic                            wr_ready_q,
	output logic                            rd_valid_q,
	output logic      [$clog2(DEPTH):0]     level
);
	localparam int AW = $clog2(DEPTH);

	// =============================================================
	// storage and pointers
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0]   count_q;
	logic [AW:0]   count_d;
	logic          do_push;
	logic          do_pop;

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("sfp_byte_fifo: DEPTH must be a power of two of at least 2");
	end

	// guarded strokes: a full push or an empty pop is dropped
	assign do_push = push && wr_ready_q;
	assign do_pop  = pop && rd_valid_q;
	assign count_d = count_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
	assign rd_data = mem[rd_ptr_q];
	assign level   = count_q;

	// data array
	always_ff @(posedge clk) begin
		if (do_push)
			mem[wr_ptr_q] <= push_data;
	end

	// pointers and registered flags
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_q   <= '0;
			rd_ptr_q   <= '0;
			count_q    <= '0;
			wr_ready_q <= 1'b0;
			rd_valid_q <= 1'b0;
		end else begin
			wr_ptr_q   <= wr_ptr_q + AW'(do_push);
			rd_ptr_q   <= rd_ptr_q + AW'(do_pop);
			count_q    <= count_d;
			wr_ready_q <= (count_d != (AW+1)'(DEPTH));
			rd_valid_q <= (count_d != '0);
		end
	end

endmodule : sfp_byte_fifo

// ---- hdl/sfp_port.sv ----
/*
 * synchronous 8-bit parallel fifo port of a usb bulk bridge: receive and
 * transmit buffers, the interface clock, the flags, strobes and bus turn.
 * assumes the usb core side runs on clk, and that the external logic runs
 * on interface_clock_out, so its pins are already in this clock domain.
 */
`timescale 1ns/1ps
`include "sfp_params.svh"

module sfp_port #(
	parameter int DATA_W     = `SFP_DATA_W,
	parameter int FIFO_DEPTH = `SFP_FIFO_DEPTH,
	parameter int IFCLK_DIV  = `SFP_IFCLK_DIV
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              cfg_fifo_family,
	input  wire logic              cfg_remote_wake_en,
	input  wire logic              mode_select_command,
	input  wire logic              mode_select_sync,
	input  wire logic              usb_suspended_flag,
	input  wire logic              rx_in_valid,
	input  wire logic [DATA_W-1:0] rx_in_data,
	output logic                   rx_in_ready,
	output logic                   tx_out_valid,
	output logic      [DATA_W-1:0] tx_out_data,
	input  wire logic              tx_out_ready,
	input  wire logic [DATA_W-1:0] parallel_data_bus_in,
	output logic      [DATA_W-1:0] parallel_data_bus_out,
	output logic                   parallel_data_bus_oe,
	input  wire logic              bus_turn_en_n,
	input  wire logic              read_strobe_n,
	input  wire logic              write_strobe_n,
	input  wire logic              flush_wake_n,
	output logic                   rx_data_avail_n,
	output logic                   tx_space_avail_n,
	output logic                   interface_clock_out,
	output sfp_pkg::sfp_mode_type  port_mode,
	output logic                   resume_req,
	output logic                   flush_req
);
	import sfp_pkg::*;

	localparam int HALF = IFCLK_DIV / 2;
	localparam int CW   = (HALF > 1) ? $clog2(HALF) : 1;
	localparam int LW   = $clog2(FIFO_DEPTH) + 1;

	initial begin
		if (IFCLK_DIV < 2 || (IFCLK_DIV % 2) != 0)
			$error("sfp_port: IFCLK_DIV must be even and at least 2");
		if (DATA_W != 8)
			$error("sfp_port: the parallel bus is 8 bits wide");
	end

	// =============================================================
	// state
	sfp_mode_type      mode_q;
	sfp_mode_type      mode_d;
	logic [CW-1:0]     div_cnt_q;
	logic              ifclk_q;
	logic              fw_prev_q;
	logic              rxf_n_q;
	logic              txe_n_q;
	logic              bus_oe_q;
	logic [DATA_W-1:0] bus_out_q;
	logic              resume_q;
	logic              flush_q;
	logic              tx_hold_valid_q;
	logic [DATA_W-1:0] tx_hold_data_q;

	// =============================================================
	// decode
	logic              active;
	logic              div_end;
	logic              tick;
	logic              rx_pop;
	logic              tx_push;
	logic              fw_strobe;
	logic              rx_push;
	logic              tx_pop;
	logic [DATA_W-1:0] rx_rd_data;
	logic [DATA_W-1:0] tx_rd_data;
	logic              rx_wr_ready;
	logic              rx_rd_valid;
	logic              tx_wr_ready;
	logic              tx_rd_valid;
	logic [LW-1:0]     rx_level;
	logic [LW-1:0]     tx_level;

	assign active  = (mode_q == SFP_MODE_SYNC);
	assign div_end = (div_cnt_q == CW'(HALF - 1));
	// tick marks the clk edge on which the interface clock rises
	assign tick    = active && div_end && !ifclk_q;

	// byte moves on the port, judged on the rising interface edge
	assign rx_pop  = tick && !rxf_n_q && !read_strobe_n;
	assign tx_push = tick && !txe_n_q && !write_strobe_n;

	// low strobe on flush/wake seen at an interface edge
	assign fw_strobe = tick && fw_prev_q && !flush_wake_n;

	// usb side handshakes
	assign rx_push = rx_in_valid;
	assign tx_pop  = tx_rd_valid && (!tx_hold_valid_q || tx_out_ready);

	// mode entry: fifo family in the stored setting, then a sync command
	always_comb begin
		mode_d = mode_q;
		if (!cfg_fifo_family)
			mode_d = SFP_MODE_IDLE;
		else if (mode_select_command)
			mode_d = mode_select_sync ? SFP_MODE_SYNC : SFP_MODE_IDLE;
	end

	// =============================================================
	// buffers
	sfp_byte_fifo #(
		.W     (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk        (clk),
		.rst_n      (rst_n),
		.push       (rx_push),
		.push_data  (rx_in_data),
		.pop        (rx_pop),
		.rd_data    (rx_rd_data),
		.wr_ready_q (rx_wr_ready),
		.rd_valid_q (rx_rd_valid),
		.level      (rx_level)
	);

	sfp_byte_fifo #(
		.W     (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk        (clk),
		.rst_n      (rst_n),
		.push       (tx_push),
		.push_data  (parallel_data_bus_in),
		.pop        (tx_pop),
		.rd_data    (tx_rd_data),
		.wr_ready_q (tx_wr_ready),
		.rd_valid_q (tx_rd_valid),
		.level      (tx_level)
	);

	// =============================================================
	// mode and interface clock divider
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q    <= SFP_MODE_IDLE;
			div_cnt_q <= '0;
			ifclk_q   <= 1'b0;
		end else begin
			mode_q <= mode_d;
			if (!active) begin
				div_cnt_q <= '0;
				ifclk_q   <= 1'b0;
			end else if (div_end) begin
				div_cnt_q <= '0;
				ifclk_q   <= !ifclk_q;
			end else begin
				div_cnt_q <= div_cnt_q + CW'(1);
			end
		end
	end

	// =============================================================
	// flags and read data, refreshed between interface edges
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxf_n_q   <= `SFP_FLAG_RST;
			txe_n_q   <= `SFP_FLAG_RST;
			bus_out_q <= `SFP_DATA_RST;
			bus_oe_q  <= 1'b0;
		end else begin
			bus_oe_q <= active && !bus_turn_en_n;
			if (!tick) begin
				rxf_n_q   <= !(active && rx_rd_valid);
				txe_n_q   <= !(active && tx_wr_ready);
				bus_out_q <= rx_rd_data;
			end
		end
	end

	// =============================================================
	// flush and wake strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fw_prev_q <= 1'b1;
			resume_q  <= 1'b0;
			flush_q   <= 1'b0;
		end else begin
			if (tick)
				fw_prev_q <= flush_wake_n;
			resume_q <= fw_strobe && usb_suspended_flag && cfg_remote_wake_en;
			flush_q  <= fw_strobe && !usb_suspended_flag;
		end
	end

	// =============================================================
	// transmit holding stage towards the usb core
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_hold_valid_q <= 1'b0;
			tx_hold_data_q  <= `SFP_DATA_RST;
		end else if (tx_pop) begin
			tx_hold_valid_q <= 1'b1;
			tx_hold_data_q  <= tx_rd_data;
		end else if (tx_out_ready) begin
			tx_hold_valid_q <= 1'b0;
		end
	end

	// =============================================================
	// outputs
	assign rx_in_ready           = rx_wr_ready;
	assign tx_out_valid          = tx_hold_valid_q;
	assign tx_out_data           = tx_hold_data_q;
	assign parallel_data_bus_out = bus_out_q;
	assign parallel_data_bus_oe  = bus_oe_q;
	assign rx_data_avail_n       = rxf_n_q;
	assign tx_space_avail_n      = txe_n_q;
	assign interface_clock_out   = ifclk_q;
	assign port_mode             = mode_q;
	assign resume_req            = resume_q;
	assign flush_req             = flush_q;

	// =============================================================
	// checks
	property p_bus_turn;
		@(posedge clk) disable iff (!rst_n)
		parallel_data_bus_oe |-> $past(active && !bus_turn_en_n);
	endproperty
	a_bus_turn: assert property (p_bus_turn) else $error("bus driven without enable");

	property p_rx_flag;
		@(posedge clk) disable iff (!rst_n)
		(tick && !rx_data_avail_n) |-> rx_rd_valid;
	endproperty
	a_rx_flag: assert property (p_rx_flag) else $error("receive flag low, buffer empty");

	property p_read_moves;
		@(posedge clk) disable iff (!rst_n)
		(tick && !rx_data_avail_n && !read_strobe_n && !(rx_push && rx_wr_ready))
			|=> rx_level == $past(rx_level) - LW'(1);
	endproperty
	a_read_moves: assert property (p_read_moves) else $error("read byte not taken");

	property p_tx_flag;
		@(posedge clk) disable iff (!rst_n)
		(tick && !tx_space_avail_n) |-> tx_wr_ready;
	endproperty
	a_tx_flag: assert property (p_tx_flag) else $error("transmit flag low, buffer full");

	property p_write_moves;
		@(posedge clk) disable iff (!rst_n)
		(tick && !tx_space_avail_n && !write_strobe_n && !tx_pop)
			|=> tx_level == $past(tx_level) + LW'(1);
	endproperty
	a_write_moves: assert property (p_write_moves) else $error("written byte lost");

	property p_write_stops;
		@(posedge clk) disable iff (!rst_n)
		(tick && write_strobe_n && !tx_pop) |=> tx_level == $past(tx_level);
	endproperty
	a_write_stops: assert property (p_write_stops) else $error("byte stored, strobe high");

	property p_read_data;
		@(posedge clk) disable iff (!rst_n)
		rx_pop |=> ##1 parallel_data_bus_out == $past(rx_rd_data);
	endproperty
	a_read_data: assert property (p_read_data) else $error("next byte not presented");

	property p_resume;
		@(posedge clk) disable iff (!rst_n)
		(fw_strobe && usb_suspended_flag && cfg_remote_wake_en) |=> resume_req && !flush_req;
	endproperty
	a_resume: assert property (p_resume) else $error("no resume on wake strobe");

	property p_flush;
		@(posedge clk) disable iff (!rst_n)
		(fw_strobe && !usb_suspended_flag) |=> flush_req && !resume_req;
	endproperty
	a_flush: assert property (p_flush) else $error("no flush on strobe");

	property p_mode_entry;
		@(posedge clk) disable iff (!rst_n)
		$rose(port_mode == SFP_MODE_SYNC) |->
			$past(cfg_fifo_family && mode_select_command && mode_select_sync);
	endproperty
	a_mode_entry: assert property (p_mode_entry) else $error("sync mode entered unasked");

	property p_ifclk;
		@(posedge clk) disable iff (!rst_n)
		$rose(interface_clock_out) |-> $past(tick);
	endproperty
	a_ifclk: assert property (p_ifclk) else $error("interface clock rose off tick");

	property p_empty_flag;
		@(posedge clk) disable iff (!rst_n)
		($fell(rx_rd_valid) && !tick) |=> rx_data_avail_n;
	endproperty
	a_empty_flag: assert property (p_empty_flag) else $error("receive flag stuck low");

endmodule : sfp_port

// ---- bench/sfp_ext_master.sv ----
/*
 * external fifo master model that faces the parallel port pins.
 * assumes the port clock is clk/2, so a clk edge seen with it low is a tick.
 */
`timescale 1ns/1ps

module sfp_ext_master (
	input  wire logic       clk,
	input  wire logic       ifclk,
	input  wire logic       rxf_n,
	input  wire logic       txf_n,
	input  wire logic [7:0] dev_data,
	input  wire logic       dev_oe,
	output logic      [7:0] bus,
	output logic            turn_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic            fw_n
);
	logic [7:0] wdata;
	logic       drv;
	logic [7:0] idle_q;
	logic [7:0] got[$];
	logic [7:0] sent[$];
	int         stalls;

	// =============================================================
	// bus level: a released bus shows a pattern that flips every cycle
	assign bus = dev_oe ? dev_data : (drv ? wdata : idle_q);
	always @(posedge clk) idle_q <= ~bus;
	initial begin
		turn_n = 1; rd_n = 1; wr_n = 1; fw_n = 1; drv = 0; wdata = 0; idle_q = 8'h5a;
		stalls = 0;
	end

	// =============================================================
	// tick waits for the port clock rising edge, all pins move 1 ns later
	// a port clock stuck high is counted as a stall instead of hanging the run
	task tick;
		int w;
		begin
			w = 0;
			@(posedge clk);
			while (ifclk && w < 8) begin
				@(posedge clk);
				w++;
			end
			if (ifclk)
				stalls++;
		end
	endtask : tick

	task read_burst(input int n, input int lim);
		int k;
		begin
			k = 0;
			tick(); #1 turn_n = 0;
			tick(); #1 rd_n = 0;
			while (n > 0 && k < lim) begin
				tick();
				if (!rxf_n && !rd_n) begin
					got.push_back(bus);
					n--;
				end
				k++;
			end
			#1 rd_n = 1;
			tick(); #1 turn_n = 1;
		end
	endtask : read_burst

	task write_burst(input logic [7:0] q[$], input int lim, input logic stall);
		int k;
		begin
			k = 0;
			tick(); #1 drv = 1;
			while (q.size() > 0 && k < lim) begin
				wdata = q[0];
				wr_n = stall && $urandom_range(3) == 0;
				tick();
				if (!txf_n && !wr_n) begin
					sent.push_back(wdata);
					void'(q.pop_front());
				end
				k++;
				#1;
			end
			wr_n = 1;
			drv = 0;
		end
	endtask : write_burst

	task strobe_fw;
		begin
			tick(); #1 fw_n = 0;
			tick(); #1 fw_n = 1;
		end
	endtask : strobe_fw
endmodule : sfp_ext_master

// ---- bench/testbench.sv ----
/*
 * self-checking bench of the parallel fifo port against queue models.
 * assumes a 10 MHz clk, port clock divided by 2 and buffers 4 deep.
 */
`timescale 1ns/1ps

module testbench;
	import sfp_pkg::*;
	logic        clk, rst_n, fam, wake_en, cmd, sync_sel, susp, rx_v, tx_rdy, drain, t;
	logic  [7:0] rx_d;
	wire logic   rx_rdy, tx_v, bus_oe, turn_n, rd_n, wr_n, fw_n, rxf_n, txf_n;
	wire logic   ifclk, res_req, fl_req;
	wire logic [7:0] tx_d, bus_out, bus;
	sfp_mode_type    mode;
	int          bad_count, checks_done, n_res, n_fl, n_rise, i, n;
	logic  [7:0] rxq[$], wq[$];

	// =============================================================
	// design and external master
	sfp_port #(.FIFO_DEPTH(4), .IFCLK_DIV(2)) dut_u (.clk(clk), .rst_n(rst_n),
		.cfg_fifo_family(fam), .cfg_remote_wake_en(wake_en), .mode_select_command(cmd),
		.mode_select_sync(sync_sel), .usb_suspended_flag(susp), .rx_in_valid(rx_v),
		.rx_in_data(rx_d), .rx_in_ready(rx_rdy), .tx_out_valid(tx_v), .tx_out_data(tx_d),
		.tx_out_ready(tx_rdy), .parallel_data_bus_in(bus), .parallel_data_bus_out(bus_out),
		.parallel_data_bus_oe(bus_oe), .bus_turn_en_n(turn_n), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n), .flush_wake_n(fw_n), .rx_data_avail_n(rxf_n),
		.tx_space_avail_n(txf_n), .interface_clock_out(ifclk), .port_mode(mode),
		.resume_req(res_req), .flush_req(fl_req));
	sfp_ext_master partner_u (.clk(clk), .ifclk(ifclk), .rxf_n(rxf_n), .txf_n(txf_n),
		.dev_data(bus_out), .dev_oe(bus_oe), .bus(bus), .turn_n(turn_n), .rd_n(rd_n),
		.wr_n(wr_n), .fw_n(fw_n));

	// =============================================================
	// clock, usb side drain and pulse counters
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end

	// watchdog: a run that stalls counts as a mismatch and ends in the report
	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		conclude();
	end
	always @(posedge clk) begin
		if (tx_v === 1'b1 && tx_rdy === 1'b1 && rst_n)
			check(tx_d, partner_u.sent.size() ? partner_u.sent.pop_front() : ~tx_d);
		n_res += (res_req === 1'b1);
		n_fl += (fl_req === 1'b1);
		#1 tx_rdy <= drain && $urandom_range(1);
	end
	always @(posedge ifclk) n_rise++;

	task check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task conclude;
		bad_count += partner_u.stalls;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : conclude

	task push_n(input int m);
		int k;
		begin
			k = 0;
			rx_v = 1;
			rx_d = 8'($urandom);
			while (m > 0 && k < 99) begin
				@(posedge clk);
				t = rx_rdy;
				k++;
				#1;
				if (t) begin
					rxq.push_back(rx_d);
					m--;
					rx_d = 8'($urandom);
				end
			end
			rx_v = 0;
			if (m > 0) begin
				bad_count++;
				conclude();
			end
		end
	endtask : push_n

	// =============================================================
	// main sequence
	initial begin
		void'($urandom(32'h7703fc1f));
		rst_n = 0; fam = 0; wake_en = 0; cmd = 0; sync_sel = 0; susp = 0;
		rx_v = 0; rx_d = 0; tx_rdy = 0; drain = 0; bad_count = 0; checks_done = 0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1;
		check(8'(rxf_n), 8'h01);
		check(8'(txf_n), 8'h01);
		check(8'(bus_oe), 8'h00);
		cmd = 1;
		sync_sel = 1;
		@(posedge clk);
		#1 cmd = 0;
		@(posedge clk);
		#1 check(8'(mode), 8'(SFP_MODE_IDLE));
		check(8'(ifclk), 8'h00);
		fam = 1;
		cmd = 1;
		@(posedge clk);
		#1 cmd = 0;
		@(posedge clk);
		#1 check(8'(mode), 8'(SFP_MODE_SYNC));
		n_rise = 0;
		repeat (20) @(posedge clk);
		#1 check(8'(n_rise), 8'h0a);
		$display("test mode done");
		for (i = 0; i < 6; i++) begin
			n = $urandom_range(4, 1);
			push_n(n);
			// the usb side sees the receive buffer full only when all four slots hold data
			check(8'(rx_rdy), 8'(n != 4));
			partner_u.read_burst(n + i % 2, 40);
			@(posedge clk);
			#1 check(8'(partner_u.got.size()), 8'(n));
			while (partner_u.got.size() > 0)
				check(partner_u.got.pop_front(), rxq.pop_front());
			check(8'(rxf_n), 8'h01);
			check(8'(bus_oe), 8'h00);
			wq.delete();
			repeat (6) wq.push_back(8'($urandom));
			drain = i > 1;
			partner_u.write_burst(wq, 20, i[0]);
			if (!drain) check(8'(txf_n), 8'h01);
			drain = 1;
			n = 0;
			while (partner_u.sent.size() > 0 && n < 200) begin
				@(posedge clk);
				n++;
			end
			#1 check(8'(partner_u.sent.size()), 8'h00);
			if (partner_u.sent.size() > 0)
				conclude();
			check(8'(txf_n), 8'h00);
			drain = 0;
		end
		$display("test transfer done");
		for (i = 0; i < 4; i++) begin
			susp = i[1];
			wake_en = i[0];
			n_res = 0;
			n_fl = 0;
			partner_u.strobe_fw();
			repeat (4) @(posedge clk);
			#1 check(8'(n_res), 8'(i == 3));
			check(8'(n_fl), 8'(i < 2));
		end
		// leaving sync mode stops the port clock, and flush/wake is ignored then
		sync_sel = 0;
		cmd = 1;
		@(posedge clk);
		#1 cmd = 0;
		@(posedge clk);
		#1 check(8'(mode), 8'(SFP_MODE_IDLE));
		check(8'(ifclk), 8'h00);
		susp = 0;
		n_fl = 0;
		partner_u.strobe_fw();
		repeat (4) @(posedge clk);
		#1 check(8'(n_fl), 8'h00);
		$display("test flush wake done");
		conclude();
	end
endmodule : testbench
